/* File: design/adc_readout_control.sv */
// Purpose: conversion handshake, busy flag and result readout sequencing
// Assumes: all pins synchronous to clock; sampleValue steady at end of conversion
// Notes:   sub-cycle figures cannot be met at 10 MHz; one cycle is the floor
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
// Operation
// - busy rises within one cycle of the convert-start falling edge
// - busy stays high at most 1.25 us outside master read after convert
// - busy falls only after the conversion end has passed
// - parallel result is on the bus before 1.25 us after convert start
// - parallel result is valid a cycle before busy falls
// - master read during convert raises frame sync about 525 ns in
// - first serial clock edge comes after frame sync is asserted
// - frame sync holds past the last serial clock edge
// - divider inputs select the least internal serial clock period
// - internal serial clock period has an upper bound per divider setting
// - busy width in master read after convert is bounded per divider
// - master read after convert raises frame sync at conversion end
// - busy falls one cycle after frame sync ends the transfer
// - serial master pins are driven only while chip select is low
// - slave mode serial data follows each rising external clock edge
// - clock source low drives internal clock, high follows host clock
// - frame sync polarity input low means active high, high means active low
// - divider inputs matter only in master read after convert
module adc_readout_control #(
    parameter int WIDTH = adc_readout_pkg::WORD_W
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             convert_start_n,
    input  wire logic             chipSelect_n,
    input  wire logic             interface_select,
    input  wire logic             clock_source_select,
    input  wire logic             frame_sync_polarity,
    input  wire logic [1:0]       serial_clock_divider,
    input  wire logic             readDuringConvert,
    input  wire logic             extSerialClock,
    input  wire logic [WIDTH-1:0] sampleValue,
    output logic                  busy,
    output logic [WIDTH-1:0]      dataBus,
    output logic                  dataBusOe,
    output logic                  frameSync,
    output logic                  frameSyncOe,
    output logic                  serialClockOut,
    output logic                  serialClockOe,
    output logic                  serial_data_out,
    output logic                  serialDataOe,
    input  wire logic [3:0]       regAddr,
    input  wire logic [31:0]      regWriteData,
    input  wire logic             regWrite,
    input  wire logic             regRead,
    output logic [31:0]           regReadData
);
    adc_readout_pkg::conv_state_t state;
    adc_readout_pkg::conv_state_t next_state;
    logic [4:0]       cnt;
    logic [4:0]       next_cnt;
    logic             next_busy;
    logic             cnvPrev;
    logic             extPrev;
    logic [WIDTH-1:0] result;
    logic [WIDTH-1:0] next_result;
    logic [WIDTH-1:0] next_dataBus;
    logic [1:0]       config_q;
    logic [1:0]       next_config;
    logic [31:0]      next_regReadData;
    logic             startEdge;
    logic             serialMode;
    logic             masterMode;
    logic             afterConvert;
    logic             duringConvert;
    logic [WIDTH-1:0] coded;
    shift_if          sh ();

    if (WIDTH != adc_readout_pkg::WORD_W) begin : g_chk
        $error("adc_readout_control: WIDTH must match the converter word");
    end

    // mode decode from the select pins, and
    assign serialMode    = interface_select;
    assign masterMode    = serialMode && !clock_source_select;
    assign afterConvert  = masterMode && !readDuringConvert;
    assign duringConvert = masterMode && readDuringConvert;
    assign startEdge     = cnvPrev && !convert_start_n;

    always_comb begin
        coded = sampleValue;
        if (config_q[adc_readout_pkg::CFG_TWOS_BIT]) begin
            coded[WIDTH-1] = ~sampleValue[WIDTH-1];
        end
    end

    // a new start is taken only in IDLE; one while busy is ignored, so the host must wait
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_busy    = busy;
        next_result  = result;
        next_dataBus = dataBus;
        sh.load      = 1'b0;
        sh.word      = result;
        case (state)
            adc_readout_pkg::IDLE: begin
                if (startEdge) begin
                    next_busy  = 1'b1;
                    next_cnt   = 5'h0;
                    next_state = adc_readout_pkg::CONVERTING;
                end
            end
            adc_readout_pkg::CONVERTING: begin
                next_cnt = cnt + 5'h1;
                if (duringConvert && cnt == adc_readout_pkg::SYNC_AT) begin
                    // previous result goes out while this one converts
                    sh.load = 1'b1;
                end
                if (cnt == adc_readout_pkg::CONV_END) begin
                    next_result = coded;
                    if (config_q[adc_readout_pkg::CFG_SWAP_BIT]) begin
                        next_dataBus = {coded[7:0], coded[WIDTH-1:8]};
                    end else begin
                        next_dataBus = coded;
                    end
                    next_state = adc_readout_pkg::FINISH;
                end
            end
            adc_readout_pkg::FINISH: begin
                // bus data settled a cycle ago; busy drops now except in master read after convert, and
                if (afterConvert) begin
                    sh.load    = 1'b1;
                    sh.word    = result;
                    next_state = adc_readout_pkg::SENDING;
                end else begin
                    if (serialMode && !masterMode) begin
                        sh.load = 1'b1;
                        sh.word = result;
                    end
                    next_busy  = 1'b0;
                    next_state = adc_readout_pkg::IDLE;
                end
            end
            adc_readout_pkg::SENDING: begin
                // busy width here is conversion plus one frame
                if (sh.done) begin
                    next_busy  = 1'b0;
                    next_state = adc_readout_pkg::IDLE;
                end
            end
            default: begin
                next_busy  = 1'b0;
                next_state = adc_readout_pkg::IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state   <= adc_readout_pkg::IDLE;
            cnt     <= 5'h0;
            busy    <= 1'b0;
            result  <= '0;
            dataBus <= '0;
            cnvPrev <= 1'b1;
            extPrev <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            busy    <= next_busy;
            result  <= next_result;
            dataBus <= next_dataBus;
            cnvPrev <= convert_start_n;
            extPrev <= extSerialClock;
        end
    end

    // divider is applied only in master read after convert
    assign sh.halfCycles = afterConvert ? adc_readout_pkg::half_cycles(serial_clock_divider)
                                        : 8'h1; // fastest period for other modes
    assign sh.master     = masterMode;
    // slave active edge is the sampled rising edge of the host clock
    assign sh.extEdge    = extSerialClock && !extPrev;

    serial_shifter #(.WIDTH(WIDTH)) u_shifter (
        .clock (clock),
        .rst_n (rst_n),
        .sh    (sh)
    );

    // pins and drive enables; the serial pins release with chip select
    assign dataBusOe       = !serialMode && !chipSelect_n;
    assign frameSync       = sh.active ^ frame_sync_polarity;
    assign frameSyncOe     = masterMode && !chipSelect_n;
    assign serialClockOut  = sh.sclk;
    assign serialClockOe   = masterMode && !chipSelect_n;
    assign serial_data_out = sh.bitOut;
    assign serialDataOe    = serialMode && !chipSelect_n;

    // register port: writes take effect at the next clock edge, reads answer one cycle later
    always_comb begin
        next_config      = config_q;
        next_regReadData = 32'h0000_0000;
        if (regWrite && regAddr == adc_readout_pkg::ADDR_CONFIG) begin
            next_config = regWriteData[1:0];
        end
        if (regRead) begin
            if (regAddr == adc_readout_pkg::ADDR_STATUS) begin
                next_regReadData[adc_readout_pkg::STAT_BUSY_BIT]  = busy;
                next_regReadData[adc_readout_pkg::STAT_SHIFT_BIT] = sh.active;
            end else if (regAddr == adc_readout_pkg::ADDR_RESULT) begin
                next_regReadData[WIDTH-1:0] = result;
            end else if (regAddr == adc_readout_pkg::ADDR_CONFIG) begin
                next_regReadData[1:0] = config_q;
            end else begin
                next_regReadData = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            config_q    <= adc_readout_pkg::CONFIG_RESET;
            regReadData <= 32'h0000_0000;
        end else begin
            config_q    <= next_config;
            regReadData <= next_regReadData;
        end
    end
endmodule

/* File: design/adc_readout_pkg.sv */
// Purpose: shared constants for the conversion and readout control block
// Assumes: 10 MHz system clock, all pins synchronous to it
// Notes:   times are kept in ns, cycle counts are derived from them
package adc_readout_pkg;
    localparam int CLK_NS            = 100;
    localparam int WORD_W            = 16;
    // least times round up, longest times round down, never below one cycle
    localparam int BUSY_RISE_MAX_NS  = 35;
    localparam int BUSY_RISE_CYCLES  = (BUSY_RISE_MAX_NS / CLK_NS) < 1 ? 1
                                       : BUSY_RISE_MAX_NS / CLK_NS;
    localparam int CONV_MAX_NS       = 1250;
    localparam int BUSY_MAX_CYCLES   = CONV_MAX_NS / CLK_NS;
    localparam int EOC_TO_BUSY_NS    = 10;
    localparam int EOC_TO_BUSY_CYC   = (EOC_TO_BUSY_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_DURING_NS    = 525;
    localparam int SYNC_DURING_CYC   = SYNC_DURING_NS / CLK_NS;
    localparam int SYNC_TO_BUSY_NS   = 25;
    localparam int SYNC_TO_BUSY_CYC  = (SYNC_TO_BUSY_NS + CLK_NS - 1) / CLK_NS;
    // end-of-conversion count: outside master read after convert, busy is then dropped EOC_TO_BUSY_CYC later
    localparam logic [4:0] CONV_END  = 5'(BUSY_MAX_CYCLES - EOC_TO_BUSY_CYC - BUSY_RISE_CYCLES);
    localparam logic [4:0] SYNC_AT   = 5'(SYNC_DURING_CYC - BUSY_RISE_CYCLES);
    // least serial clock period per divider setting, in ns
    localparam int SCLK_MIN_NS_0     = 25;
    localparam int SCLK_MIN_NS_1     = 50;
    localparam int SCLK_MIN_NS_2     = 100;
    localparam int SCLK_MIN_NS_3     = 200;
    // register map
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_RESULT = 4'h4;
    localparam logic [3:0] ADDR_CONFIG = 4'h8;
    localparam int CFG_TWOS_BIT      = 0;
    localparam int CFG_SWAP_BIT      = 1;
    localparam logic [1:0] CONFIG_RESET = 2'h0;
    localparam int STAT_BUSY_BIT     = 0;
    localparam int STAT_SHIFT_BIT    = 1;

    typedef enum logic [2:0] {IDLE, CONVERTING, FINISH, SENDING} conv_state_t;

    // half period in cycles of the internal serial clock, at least one
    function automatic logic [7:0] half_cycles(input logic [1:0] div);
        int ns;
        int cyc;
        ns = (div == 2'h0) ? SCLK_MIN_NS_0 : (div == 2'h1) ? SCLK_MIN_NS_1
           : (div == 2'h2) ? SCLK_MIN_NS_2 : SCLK_MIN_NS_3;
        cyc = (ns + 2 * CLK_NS - 1) / (2 * CLK_NS);
        if (cyc < 1) begin
            cyc = 1;
        end
        return 8'(cyc);
    endfunction
endpackage

/* File: design/shift_if.sv */
// Purpose: carrier between the readout control and its serial shifter
// Assumes: one clock domain
// Notes:   control side loads a word, shifter reports progress
`timescale 1ns/1ns
interface shift_if;
    logic                                load;
    logic [adc_readout_pkg::WORD_W-1:0]  word;
    logic                                master;
    logic                                extEdge;
    logic [7:0]                          halfCycles;
    logic                                active;
    logic                                sclk;
    logic                                bitOut;
    logic                                done;
    modport ctrl (output load, word, master, extEdge, halfCycles,
                  input  active, sclk, bitOut, done);
    modport shifter (input  load, word, master, extEdge, halfCycles,
                     output active, sclk, bitOut, done);
endinterface

/* File: design/serial_shifter.sv */
// Purpose: shifts one result word out, msb first, as master or slave
// Assumes: load only while not active
// Notes:   master data change on the falling serial clock edge
`timescale 1ns/1ns
module serial_shifter #(
    parameter int WIDTH = adc_readout_pkg::WORD_W
) (
    input  wire logic clock,
    input  wire logic rst_n,
    shift_if.shifter  sh
);
    logic [WIDTH-1:0] word;
    logic [WIDTH-1:0] next_word;
    logic [4:0]       bitCnt;
    logic [4:0]       next_bitCnt;
    logic [7:0]       phase;
    logic [7:0]       next_phase;
    logic             sclk;
    logic             next_sclk;
    logic             active;
    logic             next_active;
    logic             tail;
    logic             next_tail;
    logic             done;
    logic             next_done;

    if (WIDTH < 2 || WIDTH > 31) begin : g_chk
        $error("serial_shifter: WIDTH out of range");
    end

    always_comb begin
        next_word   = word;
        next_bitCnt = bitCnt;
        next_phase  = phase;
        next_sclk   = sclk;
        next_active = active;
        next_tail   = tail;
        next_done   = 1'b0;
        if (sh.load && !active) begin
            next_word   = sh.word;
            next_bitCnt = 5'h0;
            next_phase  = 8'h0;
            next_sclk   = 1'b0;
            next_active = 1'b1;
            next_tail   = 1'b0;
        end else if (active && tail) begin
            // frame sync held one full cycle past the last clock edge
            next_active = 1'b0;
            next_tail   = 1'b0;
            next_done   = 1'b1;
        end else if (active && sh.master) begin
            // first edge comes a half period after sync, never in its cycle
            if (phase == sh.halfCycles - 8'h1) begin
                next_phase = 8'h0;
                next_sclk  = ~sclk;
                if (sclk) begin
                    next_word   = {word[WIDTH-2:0], 1'b0};
                    next_bitCnt = bitCnt + 5'h1;
                    if (bitCnt == 5'(WIDTH - 1)) begin
                        next_tail = 1'b1;
                    end
                end
            end else begin
                next_phase = phase + 8'h1;
            end
        end else if (active && sh.extEdge) begin
            // next bit follows one cycle after the host clock edge
            next_word   = {word[WIDTH-2:0], 1'b0};
            next_bitCnt = bitCnt + 5'h1;
            if (bitCnt == 5'(WIDTH - 1)) begin
                next_active = 1'b0;
                next_done   = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            word   <= '0;
            bitCnt <= 5'h0;
            phase  <= 8'h0;
            sclk   <= 1'b0;
            active <= 1'b0;
            tail   <= 1'b0;
            done   <= 1'b0;
        end else begin
            word   <= next_word;
            bitCnt <= next_bitCnt;
            phase  <= next_phase;
            sclk   <= next_sclk;
            active <= next_active;
            tail   <= next_tail;
            done   <= next_done;
        end
    end

    assign sh.active = active;
    assign sh.sclk   = sclk;
    assign sh.bitOut = word[WIDTH-1];
    assign sh.done   = done;
endmodule

/* File: sim/adc_readout_props.sv */
// Purpose: pin timing checks for the readout control block
// Assumes: mode pins change only while no conversion runs
// Notes:   sub-cycle limits are held to whole cycles
`timescale 1ns/1ns
module adc_readout_props #(
    parameter int WIDTH = 16
) (
    input wire logic             clock,
    input wire logic             rst_n,
    input wire logic             convert_start_n,
    input wire logic             chipSelect_n,
    input wire logic             interface_select,
    input wire logic             clock_source_select,
    input wire logic             frame_sync_polarity,
    input wire logic             readDuringConvert,
    input wire logic             busy,
    input wire logic [WIDTH-1:0] dataBus,
    input wire logic             dataBusOe,
    input wire logic             frameSync,
    input wire logic             frameSyncOe,
    input wire logic             serialClockOut,
    input wire logic             serialClockOe,
    input wire logic             serialDataOe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire active  = frameSync ^ frame_sync_polarity;
    wire mAfter  = interface_select & ~clock_source_select & ~readDuringConvert;
    wire mDuring = interface_select & ~clock_source_select & readDuringConvert;

    chk_busy_rise: assert property ($fell(convert_start_n) && !busy |=> busy)
        else $error("busy did not follow convert start");
    chk_busy_width: assert property ($rose(busy) && !mAfter
        |-> ##11 busy ##1 !busy) else $error("busy width is not twelve cycles");
    chk_data_ready: assert property ($fell(busy) && !interface_select
        |-> $stable(dataBus)) else $error("parallel data changed as busy fell");
    chk_sync_during: assert property ($rose(busy) && mDuring |-> ##[4:6] active)
        else $error("frame sync late in read during convert");
    chk_sync_after: assert property ($rose(busy) && mAfter |-> ##[11:13] active)
        else $error("frame sync late in read after convert");
    chk_busy_after_sync: assert property (mAfter && busy && $past(active)
        && !active |=> !busy) else $error("busy did not fall after frame end");
    chk_first_edge: assert property ($rose(active) && frameSyncOe
        |-> !serialClockOut) else $error("serial clock high as frame starts");
    chk_last_edge: assert property ($fell(active) && frameSyncOe
        |-> !serialClockOut && !$past(serialClockOut)) else $error("no hold after last clock");
    chk_sclk_half: assert property ($rose(serialClockOut)
        |=> !serialClockOut) else $error("serial clock high phase wrong");
    chk_cs_release: assert property (chipSelect_n |-> !(frameSyncOe | dataBusOe
        | serialClockOe | serialDataOe)) else $error("pin driven while chip select high");
endmodule
bind adc_readout_control adc_readout_props #(.WIDTH(WIDTH)) adc_readout_props_inst (
    .clock(clock), .rst_n(rst_n), .convert_start_n(convert_start_n),
    .chipSelect_n(chipSelect_n), .interface_select(interface_select),
    .clock_source_select(clock_source_select), .frame_sync_polarity(frame_sync_polarity),
    .readDuringConvert(readDuringConvert), .busy(busy), .dataBus(dataBus),
    .dataBusOe(dataBusOe), .frameSync(frameSync), .frameSyncOe(frameSyncOe),
    .serialClockOut(serialClockOut), .serialClockOe(serialClockOe), .serialDataOe(serialDataOe));

/* File: sim/host_model.sv */
// Purpose: host side: starts conversions and collects serial words
// Assumes: one clock; the bench picks master or slave capture
// Notes:   host clock stands low outside slave reads
`timescale 1ns/1ns
module host_model (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        startReq,
    input  wire logic        slaveRun,
    input  wire logic        busy,
    input  wire logic        serialClockOut,
    input  wire logic        serial_data_out,
    output logic             convert_start_n,
    output logic             extSerialClock,
    output logic [15:0]      rxWord,
    output logic [4:0]       rxCount
);
    logic       sclkPrev;
    logic       pending;
    logic [1:0] phase;
    logic [5:0] gap;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            convert_start_n <= 1'b1;
            extSerialClock <= 1'b0;
            rxWord <= 16'h0000;
            rxCount <= 5'h00;
            sclkPrev <= 1'b0;
            pending <= 1'b0;
            phase <= 2'h0;
            gap <= 6'h00;
        end else begin
            sclkPrev <= serialClockOut;
            convert_start_n <= 1'b1;
            pending <= pending | startReq;
            if (gap != 6'h00) begin
                gap <= gap - 6'h01;
            end
            // a start waits for idle and for the least spacing of conversions
            if (pending && !busy && gap == 6'h00) begin
                convert_start_n <= 1'b0;
                pending <= 1'b0;
                gap <= 6'h14;
                rxCount <= 5'h00;
            end else if (!slaveRun && serialClockOut && !sclkPrev && rxCount < 5'h10) begin
                rxWord <= {rxWord[14:0], serial_data_out};
                rxCount <= rxCount + 5'h01;
            end
            // bit is taken just before each rising edge we make
            if (slaveRun && rxCount < 5'h10) begin
                phase <= phase + 2'h1;
                extSerialClock <= (phase == 2'h0) ? 1'b1 : (phase == 2'h2) ? 1'b0 : extSerialClock;
                if (phase == 2'h0) begin
                    rxWord <= {rxWord[14:0], serial_data_out};
                    rxCount <= rxCount + 5'h01;
                end
            end else begin
                phase <= 2'h0;
                extSerialClock <= 1'b0;
            end
        end
    end
endmodule

/* File: sim/testbench.sv */
// Purpose: self-checking bench for the readout control block
// Assumes: host model stands on the far side
// Notes:   random words from a fixed seed, corners mixed in
`timescale 1ns/1ns
`define CHK(got, exp) check(got, exp)
module testbench;
    logic        clock, rst_n, chipSelect_n, interface_select, clock_source_select;
    logic        frame_sync_polarity, readDuringConvert, startReq, slaveRun;
    logic        regWrite, regRead, busy, dataBusOe, frameSync, frameSyncOe;
    logic        serialClockOut, serialClockOe, serial_data_out, serialDataOe;
    logic        convert_start_n, extSerialClock;
    logic [1:0]  serial_clock_divider;
    logic [3:0]  regAddr;
    logic [4:0]  rxCount;
    logic [15:0] sampleValue, dataBus, rxWord, v, prev;
    logic [31:0] regWriteData, regReadData;
    int          n_fail, cmp_count, cycles, seed, width;

    adc_readout_control adc_readout_control_inst (.clock(clock), .rst_n(rst_n),
        .convert_start_n(convert_start_n), .chipSelect_n(chipSelect_n),
        .interface_select(interface_select), .clock_source_select(clock_source_select),
        .frame_sync_polarity(frame_sync_polarity), .serial_clock_divider(serial_clock_divider),
        .readDuringConvert(readDuringConvert), .extSerialClock(extSerialClock),
        .sampleValue(sampleValue), .busy(busy), .dataBus(dataBus), .dataBusOe(dataBusOe),
        .frameSync(frameSync), .frameSyncOe(frameSyncOe), .serialClockOut(serialClockOut),
        .serialClockOe(serialClockOe), .serial_data_out(serial_data_out),
        .serialDataOe(serialDataOe), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData));
    host_model host_model_inst (.clock(clock), .rst_n(rst_n), .startReq(startReq),
        .slaveRun(slaveRun), .busy(busy), .serialClockOut(serialClockOut),
        .serial_data_out(serial_data_out), .convert_start_n(convert_start_n),
        .extSerialClock(extSerialClock), .rxWord(rxWord), .rxCount(rxCount));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    function automatic logic [15:0] expect_word(input logic [15:0] w, input logic [1:0] cfg);
        logic [15:0] r;
        r = w;
        r[15] = r[15] ^ cfg[0];
        return cfg[1] ? {r[7:0], r[15:8]} : r;
    endfunction
    task automatic regWr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic regRd(input logic [3:0] a, input logic [31:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        @(negedge clock);
        `CHK(regReadData, exp);
        @(posedge clock);
    endtask
    // busy width is counted on falling edges, where outputs have settled
    task automatic convert(input logic [15:0] w);
        sampleValue <= w;
        startReq <= 1'b1;
        @(posedge clock);
        startReq <= 1'b0;
        width = 0;
        for (int i = 0; i < 300 && (width == 0 || busy === 1'b1); i++) begin
            @(negedge clock);
            width += (busy === 1'b1);
        end
        @(posedge clock);
    endtask
    task automatic waitRx();
        for (int i = 0; i < 200 && rxCount !== 5'h10; i++) begin
            @(negedge clock);
        end
        `CHK(rxCount, 5'h10);
        @(posedge clock);
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        {chipSelect_n, interface_select, clock_source_select, frame_sync_polarity} = 4'h0;
        {readDuringConvert, startReq, slaveRun, regWrite, regRead} = 5'h00;
        serial_clock_divider = 2'h0;
        regAddr = 4'h0;
        regWriteData = 32'h0000_0000;
        sampleValue = 16'h0000;
        seed = 32'h420f;
        rst_n = 1'b0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        regRd(adc_readout_pkg::ADDR_CONFIG, 32'h0000_0000);
        regWr(4'hC, 32'hFFFF_FFFF);
        regRd(4'hC, 32'h0000_0000);
        regWr(adc_readout_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        regRd(adc_readout_pkg::ADDR_STATUS, 32'h0000_0000);
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 3; k++) begin
                v = (k == 0) ? 16'h0000 : (k == 1) ? 16'hFFFF : 16'($random(seed));
                regWr(adc_readout_pkg::ADDR_CONFIG, 32'(c));
                regRd(adc_readout_pkg::ADDR_CONFIG, 32'(c));
                convert(v);
                `CHK(width, 12);
                `CHK(dataBus, expect_word(v, 2'(c)));
                `CHK(dataBusOe, 1'b1);
                regRd(adc_readout_pkg::ADDR_RESULT, 32'(expect_word(v, 2'(c&1))));
            end
        end
        $display("test parallel done");
        regWr(adc_readout_pkg::ADDR_CONFIG, 32'h0000_0000);
        interface_select <= 1'b1;
        for (int d = 0; d < 8; d++) begin
            serial_clock_divider <= 2'(d);
            frame_sync_polarity <= d[2];
            prev = (d == 3) ? 16'h8001 : 16'($random(seed));
            convert(prev);
            `CHK(rxCount, 5'h10);
            `CHK(width, 46);
            `CHK(rxWord, prev);
            `CHK(frameSync, d[2]);
            `CHK({frameSyncOe, serialClockOe, serialDataOe, dataBusOe}, 4'hE);
        end
        $display("test master after convert done");
        readDuringConvert <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            v = 16'($random(seed));
            convert(v);
            `CHK(width, 12);
            waitRx();
            `CHK(rxWord, prev);
            prev = v;
        end
        $display("test master during convert done");
        readDuringConvert <= 1'b0;
        clock_source_select <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 16'h7FFE : 16'($random(seed));
            convert(v);
            slaveRun <= 1'b1;
            waitRx();
            slaveRun <= 1'b0;
            `CHK(rxWord, v);
            `CHK(frameSyncOe, 1'b0);
        end
        $display("test slave done");
        chipSelect_n <= 1'b1;
        @(negedge clock);
        `CHK({frameSyncOe, serialClockOe, serialDataOe, dataBusOe}, 4'h0);
        $display("test chip select done");
        give_verdict();
    end
endmodule
